// ==== dmc_pkg.sv ====
// Shared constants and types for the DDR read-path host controller
package dmc_pkg;

	// Clocking: the link clock is hclk divided by four
	localparam int unsigned HCLK_NS = 40;
	localparam int unsigned CK_DIV  = 4;
	localparam int unsigned CK_NS   = HCLK_NS * CK_DIV;

	// Row timing in ns as rated, converted to link clocks rounding up
	localparam int unsigned ACTIVATE_TO_ACCESS_DELAY_NS = 20;
	localparam int unsigned TRC_NS  = 65;
	localparam int unsigned BANK_TO_BANK_ACTIVATE_DELAY_NS = 15;
	localparam int unsigned MINIMUM_ROW_OPEN_TIME_NS = 40;
	localparam int unsigned TRP_NS  = 20;

	function automatic int unsigned cyc_up(input int unsigned ns);
		int unsigned c;
		c = (ns + CK_NS - 1) / CK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	localparam logic [3:0] RCD_CYC = 4'(cyc_up(ACTIVATE_TO_ACCESS_DELAY_NS));
	localparam logic [3:0] RC_CYC  = 4'(cyc_up(TRC_NS));
	localparam logic [3:0] RRD_CYC = 4'(cyc_up(BANK_TO_BANK_ACTIVATE_DELAY_NS));
	localparam logic [3:0] RAS_CYC = 4'(cyc_up(MINIMUM_ROW_OPEN_TIME_NS));
	localparam logic [3:0] RP_CYC  = 4'(cyc_up(TRP_NS));
	localparam logic [3:0] MRD_CYC = 4'h2;        // Mode load settle, link clocks
	localparam logic [7:0] DLL_CYC = 8'hC8;       // 200 link clocks after DLL enable or reset

	// Rated link frequency and speed grade, for latency band checks
	localparam int unsigned CK_MHZ_RATED = 133;
	localparam logic        FAST_GRADE   = 1'b1;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [4:0] OFS_CMD   = 5'h00;
	localparam logic [4:0] OFS_ADDR  = 5'h04;
	localparam logic [4:0] OFS_STAT  = 5'h08;
	localparam logic [4:0] OFS_RD_LO = 5'h0C;
	localparam logic [4:0] OFS_RD_HI = 5'h10;

	// Field positions
	localparam int unsigned ADDR_AP_BIT = 15;
	localparam int unsigned STAT_ERR    = 1;
	localparam int unsigned STAT_DONE   = 2;

	// Reset values
	localparam logic [6:0]  MODE_RST = 7'h22;     // Burst of 4, latency 2
	localparam logic [15:0] ADDR_RST = 16'h0000;

	// Software command codes
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_LMR  = 3'b001,
		CMD_EMR  = 3'b010,
		CMD_ACT  = 3'b011,
		CMD_READ = 3'b100,
		CMD_PRE  = 3'b101,
		CMD_STOP = 3'b110
	} dmc_cmd_e;

	// Pin codes {ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		OP_LMR  = 3'b000,
		OP_PRE  = 3'b010,
		OP_ACT  = 3'b011,
		OP_STOP = 3'b110,
		OP_READ = 3'b101,
		OP_NOP  = 3'b111
	} dmc_op_e;

	// Automatic mode load sequence
	typedef enum logic [1:0] {
		SQ_IDLE   = 2'b00,
		SQ_DLLRST = 2'b01,
		SQ_NORMAL = 2'b10
	} dmc_seq_e;

endpackage : dmc_pkg

// ==== dmc_host.sv ====
// DDR SDRAM host controller: mode loads, activates, reads with capture
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Latency only 2, 2.5 or 3
// - Latency band must cover rated clock
// - Normal mode load clears bits seven upward
// - Bit 8 alone starts DLL reset
// - DLL reset load followed by normal load
// - No reserved operating mode values written
// - Bank select low set loads extended register
// - DLL enable followed by DLL reset load
// - Extended load only when idle, then wait
// - 200 clocks after DLL enable before read
// - No access before activate delay elapses
// - Precharge before activating another row
// - Same-bank activates spaced by row cycle
// - Cross-bank activates spaced by bank delay
// - Address bit 10 selects auto precharge
// - Next read after wanted pairs truncates
// - Burst stop truncates with read latency
// - Read ends or stops before write
// - Mode fields: length, type, latency, mode
// - Base load: DLL reset bit self-clears
module dmc_host (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// DRAM clock and command
	output logic             ck,
	output logic             ck_n,
	output logic             cke,
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic [1:0]       bank_sel,
	output logic [12:0]      addr,
	// DRAM data
	input  wire logic [7:0]  dq_i,
	output logic [7:0]       dq_o,
	output logic             dq_oe,
	input  wire logic        dqs_i,
	output logic             dqs_o,
	output logic             dqs_oe,
	output logic             dm
);

	logic [1:0]  ph_q;
	logic [7:0]  hc_q;
	logic        slot;
	logic        ck_q, ckn_q, cke_q;
	logic [7:0]  dq_s1_q, dq_s2_q;
	logic        a_wr_q;
	logic [2:0]  a_idx_q;
	logic [2:0]  cmd_q;
	logic [15:0] addr_q;
	logic        pend_q, err_q, done_q;
	dmc_pkg::dmc_seq_e seq_q;
	logic [6:0]  mode_q;
	logic        open_q [4];
	logic [3:0]  rcd_q [4];
	logic [3:0]  rc_q [4];
	logic [3:0]  ras_q [4];
	logic [3:0]  rp_q [4];
	logic [3:0]  rrd_q, mrd_q;
	logic [7:0]  dll_q;
	logic        go, bad;
	dmc_pkg::dmc_op_e p_op;
	logic [1:0]  p_ba;
	logic [12:0] p_a;
	logic [1:0]  bk;
	logic        idle_all;
	logic        cur_v_q, nxt_v_q;
	logic [7:0]  cur_st_q, nxt_st_q;
	logic [3:0]  cur_len_q, nxt_len_q;
	logic [7:0]  rdat_q [8];
	logic [7:0]  hc_m1, idx, stop_at;
	logic        wr_cmd, wr_stat;
	logic [2:0]  cmd_lmr;

	// Latency field to half-clock count, zero when not allowed
	function automatic logic [7:0] cl_half(input logic [2:0] f);
		case (f)
			3'b010:  cl_half = (dmc_pkg::CK_MHZ_RATED <= 133) ? 8'h04 : 8'h00;
			3'b110:  cl_half = (dmc_pkg::CK_MHZ_RATED <= 167) ? 8'h05 : 8'h00;
			3'b011:  cl_half = (dmc_pkg::FAST_GRADE && dmc_pkg::CK_MHZ_RATED >= 133) ? 8'h06 : 8'h00;
			default: cl_half = 8'h00;
		endcase
	endfunction : cl_half

	// Burst length field to element count, zero when reserved
	function automatic logic [3:0] bl_len(input logic [2:0] f);
		case (f)
			3'b001:  bl_len = 4'h2;
			3'b010:  bl_len = 4'h4;
			3'b011:  bl_len = 4'h8;
			default: bl_len = 4'h0;
		endcase
	endfunction : bl_len

	// Link clock divider; commands change on the falling link edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q  <= 2'h2;          // Low phase first, so the first rise is a full one
			hc_q  <= 8'h00;
			ck_q  <= 1'b0;
			ckn_q <= 1'b1;
			cke_q <= 1'b0;
		end else begin
			ph_q  <= ph_q + 2'h1;
			ck_q  <= (ph_q == 2'h3) || (ph_q == 2'h0);
			ckn_q <= !((ph_q == 2'h3) || (ph_q == 2'h0));
			cke_q <= 1'b1;
			if (ph_q[0]) begin
				hc_q <= hc_q + 8'h01;   // Counts link edges, both polarities
			end
		end
	end

	assign slot = (ph_q == 2'h1);
	assign ck   = ck_q;
	assign ck_n = ckn_q;
	assign cke  = cke_q;

	// Data pins pass two flops before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// Host never drives data; writes are not issued
	assign dq_o   = 8'h00;
	assign dq_oe  = 1'b0;
	assign dqs_o  = 1'b0;
	assign dqs_oe = 1'b0;
	assign dm     = 1'b0;

	// AHB-Lite address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr_q  <= 1'b0;
			a_idx_q <= 3'h0;
			hrdata  <= 32'h0000_0000;
		end else begin
			a_wr_q  <= hsel && hready && htrans[1] && hwrite;
			a_idx_q <= haddr[4:2];
			if (hsel && hready && htrans[1] && !hwrite) begin
				case ({haddr[4:2], 2'b00})
					dmc_pkg::OFS_CMD:   hrdata <= {29'h0, cmd_q};
					dmc_pkg::OFS_ADDR:  hrdata <= {16'h0000, addr_q};
					dmc_pkg::OFS_STAT:  hrdata <= {24'h0, open_q[3], open_q[2], open_q[1], open_q[0],
						dll_q != 8'h00, done_q, err_q, pend_q || seq_q != dmc_pkg::SQ_IDLE};
					dmc_pkg::OFS_RD_LO: hrdata <= {rdat_q[3], rdat_q[2], rdat_q[1], rdat_q[0]};
					dmc_pkg::OFS_RD_HI: hrdata <= {rdat_q[7], rdat_q[6], rdat_q[5], rdat_q[4]};
					default:            hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_cmd    = a_wr_q && ({a_idx_q, 2'b00} == dmc_pkg::OFS_CMD);
	assign wr_stat   = a_wr_q && ({a_idx_q, 2'b00} == dmc_pkg::OFS_STAT);

	// Command and address registers, command pending flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q  <= dmc_pkg::CMD_NONE;
			addr_q <= dmc_pkg::ADDR_RST;
			pend_q <= 1'b0;
		end else begin
			if (a_wr_q && ({a_idx_q, 2'b00} == dmc_pkg::OFS_ADDR) && !pend_q) begin
				addr_q <= hwdata[15:0];
			end
			if (wr_cmd && !pend_q && seq_q == dmc_pkg::SQ_IDLE) begin
				cmd_q  <= hwdata[2:0];
				pend_q <= 1'b1;
			end else if (seq_q == dmc_pkg::SQ_IDLE && (go || bad)) begin
				pend_q <= 1'b0;
			end
		end
	end

	// Sticky error flag; a set wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_q <= 1'b0;
		end else begin
			err_q <= (err_q && !(wr_stat && hwdata[dmc_pkg::STAT_ERR])) || bad
				|| (wr_cmd && (pend_q || seq_q != dmc_pkg::SQ_IDLE));
		end
	end

	assign bk      = addr_q[14:13];
	assign idle_all = !open_q[0] && !open_q[1] && !open_q[2] && !open_q[3] && !cur_v_q && !nxt_v_q
		&& rp_q[0] == 4'h0 && rp_q[1] == 4'h0 && rp_q[2] == 4'h0 && rp_q[3] == 4'h0;
	assign cmd_lmr = (seq_q == dmc_pkg::SQ_IDLE) ? cmd_q : dmc_pkg::CMD_LMR;

	// Command decision, once per link clock
	always_comb begin
		go   = 1'b0;
		bad  = 1'b0;
		p_op = dmc_pkg::OP_NOP;
		p_ba = 2'b00;
		p_a  = addr_q[12:0];
		if (slot && seq_q != dmc_pkg::SQ_IDLE) begin
			p_op = dmc_pkg::OP_LMR;
			p_a  = {4'h0, seq_q == dmc_pkg::SQ_DLLRST, 1'b0, mode_q};
			go   = (mrd_q == 4'h0);
		end else if (slot && pend_q) begin
			case (cmd_lmr)
				dmc_pkg::CMD_LMR: begin
					p_op = dmc_pkg::OP_LMR;
					if (cl_half(addr_q[6:4]) == 8'h00 || bl_len(addr_q[2:0]) == 4'h0
						|| addr_q[12:9] != 4'h0 || addr_q[7]) begin
						bad = 1'b1;
					end else begin
						go = idle_all && mrd_q == 4'h0;
					end
				end
				dmc_pkg::CMD_EMR: begin
					p_op = dmc_pkg::OP_LMR;
					p_ba = 2'b01;
					if (addr_q[12:2] != 11'h000) begin
						bad = 1'b1;
					end else begin
						go = idle_all && mrd_q == 4'h0;
					end
				end
				dmc_pkg::CMD_ACT: begin
					p_op = dmc_pkg::OP_ACT;
					p_ba = bk;
					if (open_q[bk]) begin
						bad = 1'b1;
					end else begin
						go = rc_q[bk] == 4'h0 && rp_q[bk] == 4'h0 && rrd_q == 4'h0;
					end
				end
				dmc_pkg::CMD_READ: begin
					p_op = dmc_pkg::OP_READ;
					p_ba = bk;
					p_a[10] = addr_q[dmc_pkg::ADDR_AP_BIT];
					if (!open_q[bk]) begin
						bad = 1'b1;
					end else begin
						go = rcd_q[bk] == 4'h0 && dll_q == 8'h00 && mrd_q == 4'h0;
					end
				end
				dmc_pkg::CMD_PRE: begin
					p_op = dmc_pkg::OP_PRE;
					p_ba = bk;
					p_a[10] = 1'b0;
					go = ras_q[bk] == 4'h0;
				end
				dmc_pkg::CMD_STOP: begin
					p_op = dmc_pkg::OP_STOP;
					go = 1'b1;
				end
				default: begin
					bad = 1'b1;
				end
			endcase
		end
	end

	// Command pins, held for a whole link clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_n     <= 1'b1;
			ras_n    <= 1'b1;
			cas_n    <= 1'b1;
			we_n     <= 1'b1;
			bank_sel <= 2'b00;
			addr     <= 13'h0000;
		end else if (slot) begin
			cs_n                  <= 1'b0;
			{ras_n, cas_n, we_n}  <= go ? p_op : dmc_pkg::OP_NOP;
			bank_sel              <= p_ba;
			addr                  <= p_a;
		end
	end

	// Stored mode bits and automatic DLL reset sequence
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= dmc_pkg::MODE_RST;
			seq_q  <= dmc_pkg::SQ_IDLE;
		end else if (go && p_op == dmc_pkg::OP_LMR) begin
			case (seq_q)
				dmc_pkg::SQ_DLLRST: seq_q <= dmc_pkg::SQ_NORMAL;
				dmc_pkg::SQ_NORMAL: seq_q <= dmc_pkg::SQ_IDLE;
				default: begin
					if (p_ba == 2'b00) begin
						mode_q <= addr_q[6:0];
						seq_q  <= addr_q[8] ? dmc_pkg::SQ_NORMAL : dmc_pkg::SQ_IDLE;
					end else begin
						seq_q <= addr_q[0] ? dmc_pkg::SQ_IDLE : dmc_pkg::SQ_DLLRST;
					end
				end
			endcase
		end
	end

	// Global waits: mode settle, bank spacing, DLL lock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mrd_q <= 4'h0;
			rrd_q <= 4'h0;
			dll_q <= 8'h00;
		end else if (slot) begin
			mrd_q <= (go && p_op == dmc_pkg::OP_LMR) ? dmc_pkg::MRD_CYC - 4'h1
				: (mrd_q != 4'h0) ? mrd_q - 4'h1 : 4'h0;
			rrd_q <= (go && p_op == dmc_pkg::OP_ACT) ? dmc_pkg::RRD_CYC - 4'h1
				: (rrd_q != 4'h0) ? rrd_q - 4'h1 : 4'h0;
			if (go && p_op == dmc_pkg::OP_LMR && (p_ba == 2'b01 ? !p_a[0] : p_a[8])) begin
				dll_q <= dmc_pkg::DLL_CYC - 8'h01;
			end else if (dll_q != 8'h00) begin
				dll_q <= dll_q - 8'h01;
			end
		end
	end

	// Per-bank row state and timers
	for (genvar b = 0; b < 4; b++) begin : g_bank
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				open_q[b] <= 1'b0;
				rcd_q[b]  <= 4'h0;
				rc_q[b]   <= 4'h0;
				ras_q[b]  <= 4'h0;
				rp_q[b]   <= 4'h0;
			end else if (slot) begin
				rcd_q[b] <= (rcd_q[b] != 4'h0) ? rcd_q[b] - 4'h1 : 4'h0;
				rc_q[b]  <= (rc_q[b] != 4'h0) ? rc_q[b] - 4'h1 : 4'h0;
				ras_q[b] <= (ras_q[b] != 4'h0) ? ras_q[b] - 4'h1 : 4'h0;
				rp_q[b]  <= (rp_q[b] != 4'h0) ? rp_q[b] - 4'h1 : 4'h0;
				if (go && p_ba == 2'(b) && p_op == dmc_pkg::OP_ACT) begin
					open_q[b] <= 1'b1;
					rcd_q[b]  <= dmc_pkg::RCD_CYC - 4'h1;
					rc_q[b]   <= dmc_pkg::RC_CYC - 4'h1;
					ras_q[b]  <= dmc_pkg::RAS_CYC - 4'h1;
				end else if (go && p_ba == 2'(b) && p_op == dmc_pkg::OP_PRE) begin
					open_q[b] <= 1'b0;
					rp_q[b]   <= dmc_pkg::RP_CYC - 4'h1;
				end else if (go && p_ba == 2'(b) && p_op == dmc_pkg::OP_READ && p_a[10]) begin
					open_q[b] <= 1'b0;
					rp_q[b]   <= dmc_pkg::RP_CYC - 4'h1 + (bl_len(mode_q[2:0]) >> 1);
				end
			end
		end
	end

	assign hc_m1   = hc_q - 8'h01;
	assign idx     = hc_m1 - cur_st_q;
	assign stop_at = hc_q + 8'h02 + cl_half(mode_q[6:4]);

	// Read burst tracking in half-clock steps and data capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_v_q   <= 1'b0;
			nxt_v_q   <= 1'b0;
			cur_st_q  <= 8'h00;
			nxt_st_q  <= 8'h00;
			cur_len_q <= 4'h0;
			nxt_len_q <= 4'h0;
			done_q    <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				rdat_q[i] <= 8'h00;
			end
		end else begin
			done_q <= done_q && !(wr_stat && hwdata[dmc_pkg::STAT_DONE]);
			if (go && p_op == dmc_pkg::OP_READ) begin
				nxt_v_q   <= 1'b1;
				nxt_st_q  <= stop_at;
				nxt_len_q <= bl_len(mode_q[2:0]);
			end else if (go && p_op == dmc_pkg::OP_STOP) begin
				if (nxt_v_q && 4'(stop_at - nxt_st_q) < nxt_len_q) begin
					nxt_len_q <= 4'(stop_at - nxt_st_q);
				end else if (!nxt_v_q && 4'(stop_at - cur_st_q) < cur_len_q) begin
					cur_len_q <= 4'(stop_at - cur_st_q);
				end
			end else if (!ph_q[0] && nxt_v_q && hc_m1 == nxt_st_q) begin
				cur_v_q   <= nxt_len_q != 4'h0;
				cur_st_q  <= nxt_st_q;
				cur_len_q <= nxt_len_q;
				nxt_v_q   <= 1'b0;
				rdat_q[0] <= dq_s2_q;
				if (nxt_len_q <= 4'h1) begin
					done_q <= 1'b1;                                 // Set wins over a clear
				end
			end else if (!ph_q[0] && cur_v_q) begin
				if (idx < {4'h0, cur_len_q}) begin
					rdat_q[idx[2:0]] <= dq_s2_q;
				end
				if (idx + 8'h01 >= {4'h0, cur_len_q}) begin
					cur_v_q <= 1'b0;
					done_q  <= 1'b1;
				end
			end
		end
	end

	// Checks on the command stream the host drives
	ck_shape_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ck) |=> ck ##1 !ck ##1 !ck ##1 ck) else $error("link clock not divided by four");
	rcd_met_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_READ |-> rcd_q[p_ba] == 4'h0 && open_q[p_ba]) else $error("read too early");
	act_closed_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_ACT |-> !open_q[p_ba] && rc_q[p_ba] == 4'h0) else $error("row still open");
	dll_lock_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_READ |-> dll_q == 8'h00) else $error("read during DLL lock");
	mode_legal_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_LMR && p_ba == 2'b00 |-> p_a[12:9] == 4'h0 && !p_a[7]
		&& (p_a[6:4] == 3'b010 || p_a[6:4] == 3'b110 || p_a[6:4] == 3'b011)) else $error("bad mode value");
	dll_follow_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_LMR && p_ba == 2'b00 && p_a[8]
		|-> ##[4:16] (go && p_op == dmc_pkg::OP_LMR && !p_a[8])) else $error("no normal load after DLL reset");
	dll_reset_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_LMR && p_ba == 2'b01 && !p_a[0]
		|-> ##[4:16] (go && p_op == dmc_pkg::OP_LMR && p_ba == 2'b00 && p_a[8])) else $error("no DLL reset");
	ext_idle_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_LMR |-> idle_all && $past(mrd_q) <= 4'h1) else $error("mode load not idle");
	rrd_met_a:
	assert property (@(posedge hclk) disable iff (!hresetn)
		go && p_op == dmc_pkg::OP_ACT |-> rrd_q == 4'h0) else $error("activates too close");

endmodule : dmc_host

// ==== dmc_dram.sv ====
// Behavioural DDR device facing the host: mode registers, banks, read bursts
`timescale 1ns/1ns
module dmc_dram (
	// Link clock and command
	input  wire logic        ck,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  bank_sel,
	input  wire logic [12:0] addr,
	// Read data and count of host breaches
	output logic [7:0]       dq,
	output logic             dqs,
	output int               viol
);
	logic [6:0] mode_q = 7'h22;
	logic [3:0] open_q = 4'h0;
	logic [7:0] base, pbase;
	logic       act = 1'b0;
	logic       need_rst = 1'b0;
	int r = 0, h = 0, st = -9, sp = -9, len = 0, plen = 0, idx = 0, dll_at = 1 << 30, last = -99;
	int act_at[4] = '{-99, -99, -99, -99};
	int free_at[4] = '{0, 0, 0, 0};

	// Idle pins at start
	initial begin
		dq = 8'h00;
		dqs = 1'b0;
		viol = 0;
	end

	// Commands on rising edges, data on both edges
	always @(ck) begin
		h++;
		if (ck && cke)
			r++;
		if (ck && !cs_n) begin
			case ({ras_n, cas_n, we_n})
				dmc_pkg::OP_LMR: begin
					if (open_q != 4'h0 || act)
						viol++;
					if (bank_sel == 2'b01) begin
						if (addr[12:2] != 11'h000)
							viol++;
						if (!addr[0]) begin
							dll_at = r;
							need_rst = 1'b1;
						end
					end else begin
						if (addr[12:9] != 4'h0 || addr[7] || !(addr[6:4] inside {3'b010, 3'b110, 3'b011})
							|| !(addr[2:0] inside {3'b001, 3'b010, 3'b011}))
							viol++;
						if (addr[8]) begin
							dll_at = r;
							need_rst = 1'b0;
						end
						mode_q = addr[6:0];
					end
				end
				dmc_pkg::OP_ACT: begin
					if (open_q[bank_sel] || r < free_at[bank_sel] || r - act_at[bank_sel] < int'(dmc_pkg::RC_CYC)
						|| r - last < int'(dmc_pkg::RRD_CYC))
						viol++;
					open_q[bank_sel] = 1'b1;
					act_at[bank_sel] = r;
					last = r;
				end
				dmc_pkg::OP_READ: begin
					if (!open_q[bank_sel] || r - act_at[bank_sel] < int'(dmc_pkg::RCD_CYC) || r - dll_at < 200
						|| need_rst)
						viol++;
					st = h + ((mode_q[6:4] == 3'b110) ? 5 : (mode_q[6:4] == 3'b011) ? 6 : 4);
					plen = (mode_q[2:0] == 3'b011) ? 8 : (mode_q[2:0] == 3'b010) ? 4 : 2;
					pbase = addr[7:0];
					if (addr[10]) begin
						open_q[bank_sel] = 1'b0;
						free_at[bank_sel] = r + plen / 2 + int'(dmc_pkg::RP_CYC);
					end
				end
				dmc_pkg::OP_STOP: sp = h + ((mode_q[6:4] == 3'b110) ? 5 : (mode_q[6:4] == 3'b011) ? 6 : 4);
				dmc_pkg::OP_PRE: begin
					open_q[bank_sel] = 1'b0;
					free_at[bank_sel] = r + int'(dmc_pkg::RP_CYC);
				end
				dmc_pkg::OP_NOP: ;
				// Self refresh never entered, so the DLL never needs re-enabling
				default: viol++;
			endcase
		end
		if (h == sp)
			act = 1'b0;
		if (h == st) begin
			act = 1'b1;
			idx = 0;
			base = pbase;
			len = plen;
		end
		if (act && idx < len) begin
			dq = base + 8'(idx);
			dqs = ck;
			idx++;
		end else begin
			act = 1'b0;
			dq = ~dq;
			dqs = ((st - h) inside {1, 2}) ? 1'b0 : ~dqs;
		end
	end
endmodule : dmc_dram

// ==== tb.sv ====
// Self-checking bench for the DDR host controller
`timescale 1ns/1ns
module tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, st;
	logic [31:0] one = 32'h0000_0001, zero = 32'h0000_0000;
	wire logic   hreadyout, hresp, ck, cke, cs_n, ras_n, cas_n, we_n, dqs;
	wire logic [31:0] hrdata;
	wire logic [1:0]  bank_sel;
	wire logic [12:0] addr;
	wire logic [7:0]  dq;
	wire logic        ck_n, dq_oe, dqs_o, dqs_oe, dm;
	wire logic [7:0]  dq_o;
	int          viol, err_count = 0, n_tests = 0;
	logic [6:0]  md[4] = '{7'h22, 7'h62, 7'h33, 7'h21};
	int          bl[4] = '{4, 4, 8, 2};
	logic [15:0] bad[5] = '{16'h0042, 16'h0082, 16'h0222, 16'h0024, 16'h0004};

	dmc_host u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr), .dq_i(dq), .dq_o(dq_o),
		.dq_oe(dq_oe), .dqs_i(dqs), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dm(dm));
	dmc_dram u_dram (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_sel(bank_sel), .addr(addr), .dq(dq), .dqs(dqs), .viol(viol));

	// 25 MHz bus clock
	always #20 hclk = ~hclk;

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic finish_test;
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// One single AHB-Lite word transfer
	task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {27'h000_0000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb

	// Load address, start a command, wait while busy
	task automatic cmd(input logic [2:0] c, input logic [15:0] a);
		ahb(1'b1, dmc_pkg::OFS_ADDR, {16'h0000, a}, st);
		ahb(1'b1, dmc_pkg::OFS_CMD, {29'h0000_0000, c}, st);
		for (int i = 0; i < 999; i++) begin
			ahb(1'b0, dmc_pkg::OFS_STAT, zero, st);
			if (st[0] === 1'b0)
				break;
		end
	endtask : cmd

	// Clear sticky error and done
	task automatic clr;
		logic [31:0] d;
		ahb(1'b1, dmc_pkg::OFS_STAT, 32'h0000_0006, d);
	endtask : clr

	// Read, optionally stopped at once, and compare n elements
	task automatic rd(input logic [15:0] a, input int n, input logic stop);
		logic [63:0] d;
		clr();
		cmd(dmc_pkg::CMD_READ, a);
		if (stop)
			cmd(dmc_pkg::CMD_STOP, a);
		for (int i = 0; i < 99 && st[dmc_pkg::STAT_DONE] !== 1'b1; i++)
			ahb(1'b0, dmc_pkg::OFS_STAT, zero, st);
		chk(32'(st[dmc_pkg::STAT_DONE]), one);
		ahb(1'b0, dmc_pkg::OFS_RD_LO, zero, d[31:0]);
		ahb(1'b0, dmc_pkg::OFS_RD_HI, zero, d[63:32]);
		for (int k = 0; k < n; k++)
			chk(32'(d[8 * k +: 8]), 32'(a[7:0] + 8'(k)));
	endtask : rd

	// Main sequence
	initial begin
		@(posedge hclk);
		#1;
		chk(32'({cke, cs_n}), one);
		chk(32'({ck, ck_n}), one);
		@(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, dmc_pkg::OFS_STAT, zero, st);
		chk(st & 32'h0000_00F7, zero);
		chk(32'(hresp), zero);
		cmd(dmc_pkg::CMD_EMR, 16'h0000);
		chk(32'(st[1]), zero);
		chk(32'(st[3]), one);
		cmd(dmc_pkg::CMD_READ, 16'h0000);
		chk(32'(st[1]), one);
		clr();
		cmd(dmc_pkg::CMD_ACT, 16'h2005);
		chk(32'(st[7:4]), 32'h0000_0002);
		cmd(dmc_pkg::CMD_ACT, 16'h2006);
		chk(32'(st[1]), one);
		rd(16'h2010, 4, 1'b0);
		cmd(dmc_pkg::CMD_PRE, 16'h2000);
		chk(32'(st[7:4]), zero);
		foreach (md[i]) begin
			cmd(dmc_pkg::CMD_LMR, {9'h000, md[i]});
			chk(32'(st[1]), zero);
			cmd(dmc_pkg::CMD_ACT, 16'h4003);
			rd(16'hC020 + 16'(i), bl[i], 1'b0);
		end
		cmd(dmc_pkg::CMD_LMR, 16'h0123);
		chk(32'(st[3]), one);
		cmd(dmc_pkg::CMD_ACT, 16'h6001);
		rd(16'h6040, 2, 1'b1);
		cmd(dmc_pkg::CMD_PRE, 16'h6000);
		foreach (bad[i]) begin
			cmd(i == 4 ? dmc_pkg::CMD_EMR : dmc_pkg::CMD_LMR, bad[i]);
			chk(32'(st[1]), one);
			clr();
		end
		for (int c = 0; c < 8; c += 7) begin
			cmd(3'(c), 16'h0000);
			chk(32'(st[1]), one);
			clr();
		end
		ahb(1'b1, 5'h14, 32'hFFFF_FFFF, st);
		ahb(1'b0, 5'h14, zero, st);
		chk(st, zero);
		chk(32'(viol), zero);
		chk(32'({dq_o, dq_oe, dqs_o, dqs_oe, dm}), zero);
		chk(32'(ck ^ ck_n), one);
		chk(32'(hreadyout), one);
		finish_test();
	end

	// Watchdog
	initial begin
		#400_000;
		err_count++;
		finish_test();
	end
endmodule : tb
